// file: hdl/alc_regs.sv
////////////////////////////////////////////////////////////////////////////////
// Light comparator with hysteresis and persistence filter
module alc_comp
    import alc_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               sys_rst_i,
    // Measurement and settings
    input  wire logic [LEVEL_W-1:0] level_i,
    input  wire logic [7:0]         cfg_i,
    input  wire logic [7:0]         day_trip_i,
    input  wire logic [7:0]         day_hys_i,
    input  wire logic [7:0]         dark_trip_i,
    input  wire logic [7:0]         dark_hys_i,
    // Decision
    output alc_zone_t               zone_o
);
    logic [11:0] cnt;
    alc_zone_t   target;

    // Daylight compares in 10 lux steps, one step is eight raw counts
    wire [10:0] day_lvl  = {1'b0, level_i[12:3]};
    wire [10:0] day_trip = {3'h0, day_trip_i};
    wire        day_on   = day_lvl >= day_trip;
    wire        day_off  = (day_lvl + {3'h0, day_hys_i}) < day_trip;
    // Dark compares in raw counts of 1.25 lux
    wire [13:0] dk_lvl   = {1'b0, level_i};
    wire [13:0] dk_trip  = {6'h00, dark_trip_i};
    wire        dark_on  = dk_lvl < dk_trip;
    wire        dark_off = dk_lvl >= (dk_trip + {6'h00, dark_hys_i});
    wire        enabled  = cfg_i[CMP_EN];
    // Longer constants need the new zone to persist longer
    wire [11:0] filt_lim = FILT_BASE_CYCLES << cfg_i[CMP_FILT_LSB +: 3];

    // Zone the level points to, from the present zone
    always_comb begin
        target = zone_o;
        case (zone_o)
            ZONE_DAY:    target = day_off ? ZONE_OFFICE : ZONE_DAY;
            ZONE_DARK:   target = dark_off ? ZONE_OFFICE : ZONE_DARK;
            ZONE_OFFICE: target = day_on ? ZONE_DAY : (dark_on ? ZONE_DARK : ZONE_OFFICE);
            default:     target = ZONE_OFFICE;
        endcase
    end

    // Persistence filter; a disabled comparator rests in office
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            zone_o <= ZONE_OFFICE;
            cnt    <= 12'h000;
        end else if (!enabled) begin
            zone_o <= ZONE_OFFICE;
            cnt    <= 12'h000;
        end else if (target == zone_o) begin
            cnt    <= 12'h000;
        end else if (cnt >= filt_lim) begin
            zone_o <= target;
            cnt    <= 12'h000;
        end else begin
            cnt    <= cnt + 12'h001;
        end
    end

    // Checks on the comparator
    property p_cmp_off;
        @(posedge clk_i) disable iff (sys_rst_i)
        !enabled |=> zone_o == ZONE_OFFICE;
    endproperty
    a_cmp_off: assert property (p_cmp_off) else $error("disabled comparator left office");
    property p_cmp_filter;
        @(posedge clk_i) disable iff (sys_rst_i)
        (enabled && $past(enabled) && zone_o != $past(zone_o)) |-> $past(cnt) >= $past(filt_lim);
    endproperty
    a_cmp_filter: assert property (p_cmp_filter) else $error("zone changed before filter time");
    property p_cmp_day;
        @(posedge clk_i) disable iff (sys_rst_i)
        (enabled && zone_o == ZONE_DAY && !day_off && cfg_i == $past(cfg_i)) |=> zone_o == ZONE_DAY;
    endproperty
    a_cmp_day: assert property (p_cmp_day) else $error("daylight left inside hysteresis");
    c_cmp_dark: cover property (@(posedge clk_i) disable iff (sys_rst_i) zone_o == ZONE_DARK);
    c_cmp_day: cover property (@(posedge clk_i) disable iff (sys_rst_i) zone_o == ZONE_DAY);
endmodule

////////////////////////////////////////////////////////////////////////////////
// Register bank behind a serial two-wire slave
module alc_regs
    import alc_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               sys_rst_i,
    // Serial bus pins
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe_n_o,
    // Sensor converter results
    input  wire logic [LEVEL_W-1:0] sensor_one_level_i,
    input  wire logic [LEVEL_W-1:0] sensor_two_level_i,
    // Device events
    input  wire logic               bl_off_req_i,
    input  wire logic               dim_set_i,
    input  wire logic               dim_clr_i,
    input  wire logic [7:0]         irq_event_i,
    // Backlight control
    output logic                    backlight_on_o,
    output logic                    dim_o,
    output logic                    standby_o,
    output logic [1:0]              zone_o
);
    logic       scl_m, scl_s, scl_d;
    logic       sda_m, sda_s, sda_d;
    alc_i2c_t   state;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic       byte_full, first, rnw, wrote, mst_nack;
    logic       wr_en;
    logic [7:0] mode_control;
    logic [7:0] interrupt_pending;
    logic [7:0] store [0:REG_COUNT-1];
    alc_zone_t  zone_one, zone_two;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
        end
    end

    // Bus events
    wire start_c  = scl_s && scl_d && sda_d && !sda_s;
    wire stop_c   = scl_s && scl_d && !sda_d && sda_s;
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;

    ////////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped offsets read as zero
    wire        in_range = ptr <= REG_LAST;
    wire [7:0]  s1_hi    = {3'h0, sensor_one_level_i[12:8]};
    wire [7:0]  s2_hi    = {3'h0, sensor_two_level_i[12:8]};
    wire [7:0]  rd_data  = !in_range           ? 8'h00 :
                           ptr == REG_ID       ? DEVICE_ID :
                           ptr == REG_MODE     ? mode_control :
                           ptr == REG_IRQ      ? interrupt_pending :
                           ptr == REG_S1_LO    ? sensor_one_level_i[7:0] :
                           ptr == REG_S1_HI    ? s1_hi :
                           ptr == REG_S2_LO    ? sensor_two_level_i[7:0] :
                           ptr == REG_S2_HI    ? s2_hi :
                           store[ptr[5:0]];

    ////////////////////////////////////////////////////////////////////////////
    // Serial slave: bits sampled on rising clock, driven after falling
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state      <= I2C_IDLE;
            bit_cnt    <= 3'h0;
            shreg      <= 8'h00;
            ptr        <= 8'h00;
            byte_full  <= 1'b0;
            first      <= 1'b0;
            rnw        <= 1'b0;
            wrote      <= 1'b0;
            mst_nack   <= 1'b0;
            wr_en      <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else begin
            wr_en <= 1'b0;
            if (start_c) begin
                state      <= I2C_ADDR;
                bit_cnt    <= 3'h0;
                byte_full  <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end else if (stop_c) begin
                state      <= I2C_IDLE;
                sda_oe_n_o <= 1'b1;
            end else if (scl_rise) begin
                if (state == I2C_RACK) begin
                    mst_nack <= sda_s;
                end else if (state == I2C_ADDR || state == I2C_WR || state == I2C_RD) begin
                    // In reads the shift also moves the next bit to the top
                    shreg     <= {shreg[6:0], sda_s};
                    bit_cnt   <= bit_cnt + 3'h1;
                    byte_full <= bit_cnt == 3'h7;
                end
            end else if (scl_fall) begin
                case (state)
                    I2C_ADDR: begin
                        if (byte_full) begin
                            byte_full <= 1'b0;
                            if (shreg[7:1] == SLAVE_ADDR) begin
                                state      <= I2C_AACK;
                                rnw        <= shreg[0];
                                first      <= 1'b1;
                                sda_oe_n_o <= 1'b0;
                            end else begin
                                state <= I2C_IDLE;
                            end
                        end
                    end
                    I2C_AACK: begin
                        if (rnw) begin
                            state      <= I2C_RD;
                            shreg      <= rd_data;
                            sda_oe_n_o <= rd_data[7];
                        end else begin
                            state      <= I2C_WR;
                            sda_oe_n_o <= 1'b1;
                        end
                    end
                    I2C_WR: begin
                        if (byte_full) begin
                            byte_full  <= 1'b0;
                            state      <= I2C_WACK;
                            sda_oe_n_o <= 1'b0;
                            first      <= 1'b0;
                            wrote      <= !first;
                            wr_en      <= !first;
                            if (first) begin
                                ptr <= shreg;
                            end
                        end
                    end
                    I2C_WACK: begin
                        state      <= I2C_WR;
                        sda_oe_n_o <= 1'b1;
                        if (wrote) begin
                            ptr <= ptr + 8'h01;
                        end
                    end
                    I2C_RD: begin
                        if (byte_full) begin
                            byte_full  <= 1'b0;
                            state      <= I2C_RACK;
                            sda_oe_n_o <= 1'b1;
                            ptr        <= ptr + 8'h01;
                        end else begin
                            sda_oe_n_o <= shreg[7];
                        end
                    end
                    I2C_RACK: begin
                        if (mst_nack) begin
                            state <= I2C_IDLE;
                        end else begin
                            state      <= I2C_RD;
                            shreg      <= rd_data;
                            sda_oe_n_o <= rd_data[7];
                        end
                    end
                    default: state <= I2C_IDLE;
                endcase
            end
        end
    end

    // The pin is only ever pulled low
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode
    wire wr_mode  = wr_en && ptr == REG_MODE;
    wire wr_irq   = wr_en && ptr == REG_IRQ;
    wire ro_hit   = ptr == REG_ID || ptr >= REG_S1_LO;
    wire wr_store = wr_en && in_range && !ro_hit && !wr_mode && !wr_irq;

    // Hardware events win over a host write in the same cycle
    wire [7:0] mode_w = wr_mode ? shreg : mode_control;
    wire [7:0] next_mode_control = {mode_w[7:5],
                                    dim_set_i | (mode_w[MODE_DIM] & ~dim_clr_i),
                                    mode_w[3:1],
                                    mode_w[MODE_BL_ON] & ~bl_off_req_i};
    wire [7:0] clr_mask = wr_irq ? shreg : 8'h00;
    wire [7:0] next_interrupt_pending = (interrupt_pending & ~clr_mask) | irq_event_i;

    // Volatile storage, lost on reset and power loss
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_control      <= MODE_RST;
            interrupt_pending <= IRQ_RST;
            for (int i = 0; i < REG_COUNT; i++) begin
                store[i] <= STORE_RST;
            end
        end else begin
            mode_control      <= next_mode_control;
            interrupt_pending <= next_interrupt_pending;
            if (wr_store) begin
                store[ptr[5:0]] <= shreg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two comparators share both threshold pairs
    alc_comp u_comp_one (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .level_i     (sensor_one_level_i),
        .cfg_i       (store[REG_CMP1[5:0]]),
        .day_trip_i  (store[REG_DAY_TRIP[5:0]]),
        .day_hys_i   (store[REG_DAY_HYS[5:0]]),
        .dark_trip_i (store[REG_DARK_TRIP[5:0]]),
        .dark_hys_i  (store[REG_DARK_HYS[5:0]]),
        .zone_o      (zone_one)
    );
    alc_comp u_comp_two (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .level_i     (sensor_two_level_i),
        .cfg_i       (store[REG_CMP2[5:0]]),
        .day_trip_i  (store[REG_DAY_TRIP[5:0]]),
        .day_hys_i   (store[REG_DAY_HYS[5:0]]),
        .dark_trip_i (store[REG_DARK_TRIP[5:0]]),
        .dark_hys_i  (store[REG_DARK_HYS[5:0]]),
        .zone_o      (zone_two)
    );

    // Zone selection: manual field or chosen sensor
    wire [7:0] cfg_reg     = store[REG_CFG[5:0]];
    wire [1:0] manual_zone = cfg_reg[CFG_ZONE_LSB +: 2];
    wire [1:0] auto_zone   = cfg_reg[CFG_SENSOR] ? zone_two : zone_one;
    wire [1:0] next_zone   = mode_control[MODE_AUTO] ? auto_zone : manual_zone;

    // Registered outputs
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            backlight_on_o <= 1'b0;
            dim_o          <= 1'b0;
            standby_o      <= 1'b1;
            zone_o         <= ZONE_OFFICE;
        end else begin
            backlight_on_o <= mode_control[MODE_BL_ON];
            dim_o          <= mode_control[MODE_BL_ON] & mode_control[MODE_DIM];
            standby_o      <= ~mode_control[MODE_NOT_STANDBY];
            zone_o         <= next_zone;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_irq_set;
        @(posedge clk_i) disable iff (sys_rst_i)
        |irq_event_i |=> (interrupt_pending & $past(irq_event_i)) == $past(irq_event_i);
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("pending event lost");
    property p_irq_clr;
        @(posedge clk_i) disable iff (sys_rst_i)
        (wr_irq && irq_event_i == 8'h00) |=> (interrupt_pending & $past(shreg)) == 8'h00;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("pending flag not cleared");
    property p_manual;
        @(posedge clk_i) disable iff (sys_rst_i)
        !mode_control[MODE_AUTO] |=> zone_o == $past(manual_zone);
    endproperty
    a_manual: assert property (p_manual) else $error("manual zone not followed");
    property p_sensor;
        @(posedge clk_i) disable iff (sys_rst_i)
        (mode_control[MODE_AUTO] && cfg_reg[CFG_SENSOR]) |=> zone_o == $past(zone_two);
    endproperty
    a_sensor: assert property (p_sensor) else $error("wrong sensor steers zone");
    property p_bl_off;
        @(posedge clk_i) disable iff (sys_rst_i)
        bl_off_req_i |=> ##1 !backlight_on_o;
    endproperty
    a_bl_off: assert property (p_bl_off) else $error("backlight not turned off");
    property p_dim;
        @(posedge clk_i) disable iff (sys_rst_i)
        (dim_set_i && mode_control[MODE_BL_ON] && !bl_off_req_i) |=> ##1 dim_o;
    endproperty
    a_dim: assert property (p_dim) else $error("dim level not applied");
    property p_standby;
        @(posedge clk_i) disable iff (sys_rst_i)
        !mode_control[MODE_NOT_STANDBY] |=> standby_o;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");
    property p_hi_zero;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ptr == REG_S1_HI || ptr == REG_S2_HI) |-> rd_data[7:5] == 3'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("high level bits not zero");
    property p_level;
        @(posedge clk_i) disable iff (sys_rst_i)
        ptr == REG_S2_LO |-> rd_data == sensor_two_level_i[7:0];
    endproperty
    a_level: assert property (p_level) else $error("sensor level misplaced");
    property p_unmapped;
        @(posedge clk_i) disable iff (sys_rst_i)
        !in_range |-> rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped offset not zero");
    c_write: cover property (@(posedge clk_i) disable iff (sys_rst_i) wr_en);
    c_read: cover property (@(posedge clk_i) disable iff (sys_rst_i) state == I2C_RACK && !mst_nack);
    c_clear: cover property (@(posedge clk_i) disable iff (sys_rst_i) wr_irq && interrupt_pending != 8'h00);
endmodule

// file: hdl/alc_pkg.sv
// Overview of operation
// - first comparator configured by 0x1B low field
// - second comparator configured by 0x1C low field
// - upper three bits set comparator filter time
// - shared daylight trip 0x1D, hysteresis 0x1E
// - shared dark trip 0x1F, hysteresis 0x20
// - daylight step 10 lux, dark 1.25 lux
// - auto bit picks comparator or manual zone
// - configuration bit 6 selects active phototransistor
// - raw level is 13 bits, high:low bytes
// - sensor levels at 0x21..0x22 and 0x23..0x24
// - mode bit 0 enables backlight, hardware clears
// - mode bit 4 dims enabled backlight, hardware settable
// - mode bit 5 clear puts device in standby
// - writing ones clears pending interrupt flags
// - registers 0x00 through 0x24 all readable
// - register contents are volatile flip-flops only
// - pending flags read at offset 0x02
package alc_pkg;
    // Register offsets
    localparam logic [7:0] REG_ID        = 8'h00;
    localparam logic [7:0] REG_MODE      = 8'h01;
    localparam logic [7:0] REG_IRQ       = 8'h02;
    localparam logic [7:0] REG_CFG       = 8'h04;
    localparam logic [7:0] REG_CMP1      = 8'h1B;
    localparam logic [7:0] REG_CMP2      = 8'h1C;
    localparam logic [7:0] REG_DAY_TRIP  = 8'h1D;
    localparam logic [7:0] REG_DAY_HYS   = 8'h1E;
    localparam logic [7:0] REG_DARK_TRIP = 8'h1F;
    localparam logic [7:0] REG_DARK_HYS  = 8'h20;
    localparam logic [7:0] REG_S1_LO     = 8'h21;
    localparam logic [7:0] REG_S1_HI     = 8'h22;
    localparam logic [7:0] REG_S2_LO     = 8'h23;
    localparam logic [7:0] REG_S2_HI     = 8'h24;
    localparam logic [7:0] REG_LAST      = 8'h24;
    localparam int         REG_COUNT     = 37;
    // Field positions
    localparam int MODE_BL_ON   = 0;
    localparam int MODE_AUTO    = 1;
    localparam int MODE_DIM     = 4;
    localparam int MODE_NOT_STANDBY   = 5;
    localparam int CFG_ZONE_LSB = 3;
    localparam int CFG_SENSOR   = 6;
    localparam int CMP_EN       = 0;
    localparam int CMP_FILT_LSB = 5;
    localparam int LEVEL_W      = 13;
    // Reset values
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] IRQ_RST   = 8'h00;
    localparam logic [7:0] STORE_RST = 8'h00;
    // Arbitrary identity and bus address values
    localparam logic [7:0] DEVICE_ID  = 8'h5A;
    localparam logic [6:0] SLAVE_ADDR = 7'h2A;
    // Filter timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int FILT_BASE_NS  = 320;
    localparam logic [11:0] FILT_BASE_CYCLES = 12'((FILT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Brightness zones
    typedef enum logic [1:0] {
        ZONE_DAY    = 2'h0,
        ZONE_OFFICE = 2'h1,
        ZONE_DARK   = 2'h2
    } alc_zone_t;
    // Serial slave states, Gray along the usual path
    typedef enum logic [2:0] {
        I2C_IDLE = 3'h0,
        I2C_ADDR = 3'h1,
        I2C_AACK = 3'h3,
        I2C_WR   = 3'h2,
        I2C_WACK = 3'h6,
        I2C_RD   = 3'h7,
        I2C_RACK = 3'h5
    } alc_i2c_t;
endpackage

// file: bench/alc_host.sv
////////////////////////////////////////
// Bus host on the two-wire link
module alc_host
    import alc_pkg::*;
(
    // Clock
    input  wire logic       clk_i,
    // Device drive of the data pin
    input  wire logic       dev_sda_i,
    input  wire logic       dev_oe_n_i,
    // Bus lines and results
    output logic            scl_o,
    output logic            sda_o,
    output logic [8:0]      res_o,
    output logic            vld_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv;
    // Pulled-up wire, low if either party drives low
    assign sda_o = drv & (dev_oe_n_i | dev_sda_i);
    initial begin
        drv = 1'b1;
        scl_o = 1'b1;
        vld_o = 1'b0;
        res_o = 9'h000;
    end
    task automatic hc(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    // Five cycles a phase keeps clear of the synchroniser delay
    task automatic bt(input logic b, output logic r);
        drv = b;
        hc(5);
        scl_o = 1'b1;
        hc(5);
        r = sda_o;
        scl_o = 1'b0;
        hc(1);
    endtask
    task automatic by(input logic [7:0] d, output logic [7:0] q, output logic n);
        for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
        bt(1'b1, n);
    endtask
    task automatic st();
        drv = 1'b1;
        hc(5);
        scl_o = 1'b1;
        hc(5);
        drv = 1'b0;
        hc(5);
        scl_o = 1'b0;
        hc(1);
    endtask
    // Pointer write, then data write or repeated start and one read byte
    task automatic go(input logic [6:0] sa, input logic [7:0] a, input logic [7:0] d, input logic rd);
        logic [7:0] q;
        logic       n0;
        logic       n;
        st();
        by({sa, 1'b0}, q, n0);
        by(a, q, n);
        if (rd) begin
            st();
            by({sa, 1'b1}, q, n);
            by(8'hFF, q, n);
        end else by(d, q, n);
        drv = 1'b0;
        hc(5);
        scl_o = 1'b1;
        hc(5);
        drv = 1'b1;
        hc(5);
        res_o = {n0, rd ? q : 8'h00};
        vld_o = 1'b1;
        hc(1);
        vld_o = 1'b0;
    endtask
endmodule

// file: bench/alc_regs_test.sv
module alc_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import alc_pkg::*;
    logic        clk_i = 0, sys_rst_i = 1, bl_off = 0, dset = 0, dclr = 0;
    logic        scl, sda, sda_o, sda_oe_n_o, vld, bl, dim, stb;
    logic [12:0] lv1 = 0, lv2 = 0;
    logic [7:0]  irq = 0, d;
    logic [8:0]  res;
    logic [1:0]  zone;
    logic [8:0]  exp_q[$];
    int          error_cnt = 0, samples_checked = 0;
    alc_regs uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .sensor_one_level_i(lv1), .sensor_two_level_i(lv2), .bl_off_req_i(bl_off),
        .dim_set_i(dset), .dim_clr_i(dclr), .irq_event_i(irq), .backlight_on_o(bl), .dim_o(dim),
        .standby_o(stb), .zone_o(zone));
    alc_host host (.clk_i(clk_i), .dev_sda_i(sda_o), .dev_oe_n_i(sda_oe_n_o), .scl_o(scl), .sda_o(sda),
        .res_o(res), .vld_o(vld));
    // Clock
    initial forever #10 clk_i = ~clk_i;
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        exp_q.push_back(9'h000);
        host.go(SLAVE_ADDR, a, v, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        exp_q.push_back(e);
        host.go(SLAVE_ADDR, a, 8'h00, 1'b1);
    endtask
    // Pins as {on, dim, standby, zone}
    task automatic pins(input logic [4:0] e);
        chk({4'h0, bl, dim, stb, zone}, {4'h0, e});
    endtask
    // Each host result is matched against the oldest expectation
    always @(posedge clk_i) if (vld) chk(res, exp_q.pop_front());
    // Watchdog, well beyond the roughly 15k cycles the sequence needs
    initial begin
        step(40000);
        error_cnt++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        void'($urandom(68));
        step(10);
        sys_rst_i = 0;
        step(5);
        chk({6'h00, bl, dim, stb}, 9'h001);
        rd(REG_ID, {1'b0, DEVICE_ID});
        rd(8'h30, 9'h000);
        for (int a = 8'h1B; a <= 8'h20; a++) begin
            d = 8'($urandom);
            wr(8'(a), d);
            rd(8'(a), {1'b0, d});
        end
        lv1 = 13'($urandom);
        lv2 = 13'($urandom);
        wr(REG_S1_LO, 8'hFF);
        rd(REG_S1_LO, {1'b0, lv1[7:0]});
        rd(REG_S1_HI, {4'h0, lv1[12:8]});
        rd(REG_S2_LO, {1'b0, lv2[7:0]});
        rd(REG_S2_HI, {4'h0, lv2[12:8]});
        wr(REG_CFG, 8'h10);
        wr(REG_MODE, 8'h31);
        pins(5'b11010);
        bl_off = 1;
        step(1);
        bl_off = 0;
        rd(REG_MODE, 9'h030);
        dclr = 1;
        step(1);
        dclr = 0;
        rd(REG_MODE, 9'h020);
        pins(5'b00010);
        // Hardware dim request on a lit backlight
        wr(REG_MODE, 8'h21);
        dset = 1;
        step(1);
        dset = 0;
        rd(REG_MODE, 9'h031);
        pins(5'b11010);
        d = 8'($urandom) | 8'h01;
        irq = d;
        step(1);
        irq = 0;
        rd(REG_IRQ, {1'b0, d});
        wr(REG_IRQ, 8'hFF);
        rd(REG_IRQ, 9'h000);
        // Bright sensor one, dark sensor two; zero hysteresis frees stale states
        lv1 = 13'h1FFF;
        lv2 = 13'h0000;
        wr(REG_DAY_HYS, 8'h00);
        wr(REG_DARK_HYS, 8'h00);
        wr(REG_DAY_TRIP, 8'h10);
        wr(REG_DARK_TRIP, 8'h10);
        wr(REG_CMP1, 8'h01);
        wr(REG_CMP2, 8'h01);
        wr(REG_CFG, 8'h00);
        wr(REG_MODE, 8'h22);
        step(300);
        pins(5'b00000);
        wr(REG_CFG, 8'h40);
        step(300);
        pins(5'b00010);
        exp_q.push_back(9'h1FF);
        host.go(SLAVE_ADDR ^ 7'h01, REG_ID, 8'h00, 1'b1);
        step(5);
        report_and_stop();
    end
endmodule
